// ===== rtl/maint_discovery_sequencer.sv
// apb-controlled maintenance window and link bring-up sequencer
module maint_discovery_sequencer #(
  parameter logic [31:0] switch_ident = 32'h0001_0001, // arbitrary value
  parameter logic [31:0] processor_ident = 32'h0002_0001 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output maint_seq_pkg::maint_req_s maint_req,
  output logic maint_req_valid,
  input wire logic maint_rsp_valid,
  input wire logic [31:0] maint_rsp_data,
  input wire logic maint_rsp_error
);

  logic [31:0] target;
  logic [7:0] host_id;
  logic [31:0] identity;
  logic [7:0] port_total;
  logic [7:0] host_port;
  logic [31:0] lock_value;
  logic [2:0] fail_code;
  logic is_switch;
  logic is_processor;

  maint_seq_pkg::seq_state_e seq_state;
  maint_seq_pkg::eng_state_e eng_state;
  maint_seq_pkg::maint_req_s seq_op;
  logic seq_issued;
  logic apb_issued;
  logic owner_apb;

  // link answer comes from another domain: two flops before any use
  logic rsp_valid_s1;
  logic rsp_valid_s2;
  logic [31:0] rsp_data_s1;
  logic [31:0] rsp_data_s2;
  logic rsp_error_s1;
  logic rsp_error_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_s1 <= 1'b0;
      rsp_valid_s2 <= 1'b0;
      rsp_data_s1 <= 32'h0000_0000;
      rsp_data_s2 <= 32'h0000_0000;
      rsp_error_s1 <= 1'b0;
      rsp_error_s2 <= 1'b0;
    end else begin
      rsp_valid_s1 <= maint_rsp_valid;
      rsp_valid_s2 <= rsp_valid_s1;
      rsp_data_s1 <= maint_rsp_data;
      rsp_data_s2 <= rsp_data_s1;
      rsp_error_s1 <= maint_rsp_error;
      rsp_error_s2 <= rsp_error_s1;
    end
  end

  // apb decode
  logic setup;
  logic is_win;
  logic reg_hit;
  logic reg_write;
  logic start_req;
  logic seq_active;
  logic seq_want;
  logic apb_win_req;
  logic eng_done;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign is_win = paddr[15:12] == maint_seq_pkg::WIN_SEL;
  assign reg_hit = paddr == maint_seq_pkg::OFF_TARGET || paddr == maint_seq_pkg::OFF_CONTROL
                || paddr == maint_seq_pkg::OFF_STATUS || paddr == maint_seq_pkg::OFF_IDENTITY
                || paddr == maint_seq_pkg::OFF_PORT_INFO
                || paddr == maint_seq_pkg::OFF_LOCK_VALUE;
  // writes land at the edge where the master sees pready
  assign reg_write = psel & penable & pready & pwrite & reg_hit;
  assign start_req = reg_write && paddr == maint_seq_pkg::OFF_CONTROL
                  && pwdata[maint_seq_pkg::CTL_START_BIT] && !seq_active;
  assign seq_active = seq_state != maint_seq_pkg::SEQ_IDLE
                   && seq_state != maint_seq_pkg::SEQ_DONE
                   && seq_state != maint_seq_pkg::SEQ_FAIL;
  assign seq_want = seq_active & ~seq_issued;
  assign apb_win_req = psel & penable & is_win & ~apb_issued & ~pready;
  assign eng_done = eng_state == maint_seq_pkg::ENG_WAIT && rsp_valid_s2;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      maint_seq_pkg::OFF_TARGET: rd_mux = target;
      maint_seq_pkg::OFF_CONTROL: rd_mux = {16'h0000, host_id, 8'h00};
      maint_seq_pkg::OFF_STATUS: rd_mux = {17'h0_0000, fail_code, is_processor, is_switch,
                                           seq_state == maint_seq_pkg::SEQ_FAIL,
                                           seq_state == maint_seq_pkg::SEQ_DONE,
                                           seq_active, 6'h00, eng_state != maint_seq_pkg::ENG_IDLE};
      maint_seq_pkg::OFF_IDENTITY: rd_mux = identity;
      maint_seq_pkg::OFF_PORT_INFO: rd_mux = {16'h0000, port_total, host_port};
      maint_seq_pkg::OFF_LOCK_VALUE: rd_mux = lock_value;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: registers answer in the first access cycle, the window when the link answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (pready) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup && !is_win) begin
      pready <= 1'b1;
      prdata <= rd_mux;
      pslverr <= ~reg_hit;
    end else if (eng_done && owner_apb) begin
      pready <= 1'b1;
      prdata <= rsp_data_s2;
      pslverr <= rsp_error_s2;
    end
  end

  // software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target <= maint_seq_pkg::TARGET_RESET;
      host_id <= maint_seq_pkg::HOST_ID_RESET;
    end else if (reg_write && paddr == maint_seq_pkg::OFF_TARGET) begin
      target <= pwdata;
    end else if (reg_write && paddr == maint_seq_pkg::OFF_CONTROL && !seq_active) begin
      host_id <= pwdata[maint_seq_pkg::CTL_HOST_MSB:maint_seq_pkg::CTL_HOST_LSB];
    end
  end

  // operation wanted by the current sequencer step
  always_comb begin
    seq_op = '0;
    seq_op.dest = maint_seq_pkg::DEST_INITIAL;
    seq_op.hop = maint_seq_pkg::HOP_ADJACENT;
    case (seq_state)
      maint_seq_pkg::SEQ_IDENT: seq_op.offset = maint_seq_pkg::MOFF_IDENTITY;
      maint_seq_pkg::SEQ_PORT_INFO: seq_op.offset = maint_seq_pkg::MOFF_PORT_INFO;
      maint_seq_pkg::SEQ_LOCK_READ: seq_op.offset = maint_seq_pkg::MOFF_HOST_LOCK;
      maint_seq_pkg::SEQ_LOCK_WRITE: begin
        seq_op.write = 1'b1;
        seq_op.offset = maint_seq_pkg::MOFF_HOST_LOCK;
        seq_op.wdata = {24'h00_0000, host_id};
      end
      maint_seq_pkg::SEQ_LOCK_CHECK: seq_op.offset = maint_seq_pkg::MOFF_HOST_LOCK;
      maint_seq_pkg::SEQ_ROUTE_DEST: begin
        seq_op.write = 1'b1;
        seq_op.offset = maint_seq_pkg::MOFF_ROUTE_DEST;
        seq_op.wdata = {24'h00_0000, host_id};
      end
      maint_seq_pkg::SEQ_ROUTE_PORT: begin
        seq_op.write = 1'b1;
        seq_op.offset = maint_seq_pkg::MOFF_ROUTE_PORT;
        seq_op.wdata = {24'h00_0000, host_port};
      end
      default: seq_op.offset = maint_seq_pkg::MOFF_IDENTITY;
    endcase
  end

  // link engine: one request at a time, four-phase handshake with the far side;
  // the sequencer wins over a window access so bring-up is never interleaved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_state <= maint_seq_pkg::ENG_IDLE;
      maint_req <= '0;
      maint_req_valid <= 1'b0;
      owner_apb <= 1'b0;
      seq_issued <= 1'b0;
      apb_issued <= 1'b0;
    end else begin
      case (eng_state)
        maint_seq_pkg::ENG_IDLE: begin
          if (seq_want) begin
            maint_req <= seq_op;
            maint_req_valid <= 1'b1;
            owner_apb <= 1'b0;
            seq_issued <= 1'b1;
            eng_state <= maint_seq_pkg::ENG_WAIT;
          end else if (apb_win_req) begin
            maint_req.write <= pwrite;
            maint_req.dest <= target[maint_seq_pkg::TGT_DEST_MSB:maint_seq_pkg::TGT_DEST_LSB];
            maint_req.hop <= target[maint_seq_pkg::TGT_HOP_MSB:maint_seq_pkg::TGT_HOP_LSB];
            maint_req.offset <= {target[maint_seq_pkg::TGT_CFG_MSB:maint_seq_pkg::TGT_CFG_LSB],
                                 paddr[maint_seq_pkg::WIN_LOW_BITS-1:0]};
            maint_req.wdata <= pwdata;
            maint_req_valid <= 1'b1;
            owner_apb <= 1'b1;
            apb_issued <= 1'b1;
            eng_state <= maint_seq_pkg::ENG_WAIT;
          end
        end
        maint_seq_pkg::ENG_WAIT: begin
          if (rsp_valid_s2) begin
            maint_req_valid <= 1'b0;
            eng_state <= maint_seq_pkg::ENG_RELEASE;
            if (owner_apb) begin
              apb_issued <= 1'b0;
            end else begin
              seq_issued <= 1'b0;
            end
          end
        end
        maint_seq_pkg::ENG_RELEASE: begin
          // no new request until the far side has dropped its answer
          if (!rsp_valid_s2) begin
            eng_state <= maint_seq_pkg::ENG_IDLE;
          end
        end
        default: eng_state <= maint_seq_pkg::ENG_IDLE;
      endcase
    end
  end

  // bring-up sequencer: advances only on the answer to its own request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state <= maint_seq_pkg::SEQ_IDLE;
      fail_code <= maint_seq_pkg::FAIL_NONE;
      is_switch <= 1'b0;
      is_processor <= 1'b0;
      identity <= 32'h0000_0000;
      port_total <= 8'h00;
      host_port <= 8'h00;
      lock_value <= 32'h0000_0000;
    end else if (start_req) begin
      seq_state <= maint_seq_pkg::SEQ_IDENT;
      fail_code <= maint_seq_pkg::FAIL_NONE;
      is_switch <= 1'b0;
      is_processor <= 1'b0;
    end else if (eng_done && !owner_apb) begin
      if (rsp_error_s2) begin
        seq_state <= maint_seq_pkg::SEQ_FAIL;
        fail_code <= maint_seq_pkg::FAIL_LINK;
      end else begin
        case (seq_state)
          maint_seq_pkg::SEQ_IDENT: begin
            identity <= rsp_data_s2;
            if (rsp_data_s2 == switch_ident) begin
              is_switch <= 1'b1;
              seq_state <= maint_seq_pkg::SEQ_PORT_INFO;
            end else if (rsp_data_s2 == processor_ident) begin
              is_processor <= 1'b1;
              seq_state <= maint_seq_pkg::SEQ_DONE;
            end else begin
              seq_state <= maint_seq_pkg::SEQ_FAIL;
              fail_code <= maint_seq_pkg::FAIL_UNKNOWN;
            end
          end
          maint_seq_pkg::SEQ_PORT_INFO: begin
            port_total <= rsp_data_s2[15:8];
            host_port <= rsp_data_s2[7:0];
            seq_state <= maint_seq_pkg::SEQ_LOCK_READ;
          end
          maint_seq_pkg::SEQ_LOCK_READ: begin
            lock_value <= rsp_data_s2;
            if (rsp_data_s2 == maint_seq_pkg::LOCK_FREE) begin
              seq_state <= maint_seq_pkg::SEQ_LOCK_WRITE;
            end else begin
              seq_state <= maint_seq_pkg::SEQ_FAIL;
              fail_code <= maint_seq_pkg::FAIL_LOCKED;
            end
          end
          maint_seq_pkg::SEQ_LOCK_WRITE: seq_state <= maint_seq_pkg::SEQ_LOCK_CHECK;
          maint_seq_pkg::SEQ_LOCK_CHECK: begin
            lock_value <= rsp_data_s2;
            if (rsp_data_s2 == {24'h00_0000, host_id}) begin
              seq_state <= maint_seq_pkg::SEQ_ROUTE_DEST;
            end else begin
              seq_state <= maint_seq_pkg::SEQ_FAIL;
              fail_code <= maint_seq_pkg::FAIL_REFUSED;
            end
          end
          maint_seq_pkg::SEQ_ROUTE_DEST: seq_state <= maint_seq_pkg::SEQ_ROUTE_PORT;
          maint_seq_pkg::SEQ_ROUTE_PORT: seq_state <= maint_seq_pkg::SEQ_DONE;
          default: seq_state <= seq_state;
        endcase
      end
    end
  end

endmodule

// ===== include/maint_seq_pkg.sv
// constants, request carrier and state types for the maintenance discovery sequencer
package maint_seq_pkg;

  // apb byte offsets of the block's own registers
  localparam logic [15:0] OFF_TARGET = 16'h0000;
  localparam logic [15:0] OFF_CONTROL = 16'h0004;
  localparam logic [15:0] OFF_STATUS = 16'h0008;
  localparam logic [15:0] OFF_IDENTITY = 16'h000c;
  localparam logic [15:0] OFF_PORT_INFO = 16'h0010;
  localparam logic [15:0] OFF_LOCK_VALUE = 16'h0014;
  // maintenance window: paddr[15:12] selects it, paddr[11:0] is the low offset
  localparam logic [3:0] WIN_SEL = 4'h1;
  localparam int WIN_LOW_BITS = 12;

  // outbound_maint_target fields, bit 0 = lsb (printed msb-first bits 2-9, 12-19, 20-31)
  localparam int TGT_DEST_LSB = 22;
  localparam int TGT_DEST_MSB = 29;
  localparam int TGT_HOP_LSB = 12;
  localparam int TGT_HOP_MSB = 19;
  localparam int TGT_CFG_LSB = 0;
  localparam int TGT_CFG_MSB = 11;
  localparam logic [31:0] TARGET_RESET = 32'h3fc0_0000;

  // control register fields
  localparam int CTL_START_BIT = 0;
  localparam int CTL_HOST_LSB = 8;
  localparam int CTL_HOST_MSB = 15;
  localparam logic [7:0] HOST_ID_RESET = 8'h00;

  // maintenance register offsets on the far side
  localparam logic [23:0] MOFF_IDENTITY = 24'h00_0000;
  localparam logic [23:0] MOFF_PORT_INFO = 24'h00_0014;
  localparam logic [23:0] MOFF_HOST_LOCK = 24'h00_0068;
  localparam logic [23:0] MOFF_ROUTE_DEST = 24'h00_0070;
  localparam logic [23:0] MOFF_ROUTE_PORT = 24'h00_0074;
  localparam logic [7:0] DEST_INITIAL = 8'hff;
  localparam logic [7:0] HOP_ADJACENT = 8'h00;
  localparam logic [31:0] LOCK_FREE = 32'h0000_ffff;

  // failure codes in the status register
  localparam logic [2:0] FAIL_NONE = 3'h0;
  localparam logic [2:0] FAIL_UNKNOWN = 3'h1;
  localparam logic [2:0] FAIL_LOCKED = 3'h2;
  localparam logic [2:0] FAIL_REFUSED = 3'h3;
  localparam logic [2:0] FAIL_LINK = 3'h4;

  typedef struct packed {
    logic write;
    logic [7:0] dest;
    logic [7:0] hop;
    logic [23:0] offset;
    logic [31:0] wdata;
  } maint_req_s;

  typedef enum {
    SEQ_IDLE,
    SEQ_IDENT,
    SEQ_PORT_INFO,
    SEQ_LOCK_READ,
    SEQ_LOCK_WRITE,
    SEQ_LOCK_CHECK,
    SEQ_ROUTE_DEST,
    SEQ_ROUTE_PORT,
    SEQ_DONE,
    SEQ_FAIL
  } seq_state_e;

  typedef enum {
    ENG_IDLE,
    ENG_WAIT,
    ENG_RELEASE
  } eng_state_e;

endpackage

// ===== sim/maint_seq_checker.sv
// concurrent checks on the sequencer's apb and link ports
module maint_seq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire maint_seq_pkg::maint_req_s maint_req,
  input wire logic maint_req_valid,
  input wire logic maint_rsp_valid,
  input wire logic [31:0] maint_rsp_data,
  input wire logic maint_rsp_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] tgt;
  logic win;
  logic regs;
  assign win = psel && penable && paddr[15:12] == maint_seq_pkg::WIN_SEL;
  assign regs = paddr inside {16'h0000, 16'h0004, 16'h0008, 16'h000c, 16'h0010, 16'h0014};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the target register so window packets can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt <= 32'h3fc0_0000;
    end else if (psel && penable && pready && pwrite && paddr == 16'h0000) begin
      tgt <= pwdata;
    end
  end
  sequence start_s;
    psel && penable && pready && pwrite && paddr == maint_seq_pkg::OFF_CONTROL && pwdata[0];
  endsequence
  sequence ident_rd_s;
    $rose(maint_req_valid) && !maint_req.write && maint_req.offset == 24'h0;
  endsequence
  AST_FIRST_IDENT: assert property (
    start_s |-> ##[1:8] ident_rd_s) else $error("first access is not the identity read");
  AST_SEQ_ADDR: assert property (
    $rose(maint_req_valid) && !win |-> maint_req.dest == 8'hff && maint_req.hop == 8'h00)
    else $error("sequencer packet not aimed at the adjacent device");
  AST_WIN_FIELDS: assert property (
    $rose(maint_req_valid) && win |-> maint_req.dest == tgt[29:22]
    && maint_req.hop == tgt[19:12] && maint_req.offset == {tgt[11:0], paddr[11:0]})
    else $error("window packet fields differ from the target register");
  AST_WIN_KIND: assert property (
    $rose(maint_req_valid) && win |-> maint_req.write == pwrite
    && (!pwrite || maint_req.wdata == pwdata)) else $error("window packet kind or data wrong");
  AST_REQ_HOLD: assert property (
    maint_req_valid && $past(maint_req_valid) |-> $stable(maint_req))
    else $error("request changed while outstanding");
  AST_RSP_DONE: assert property (
    $rose(maint_req_valid) |-> !maint_rsp_valid) else $error("request issued before answer dropped");
  AST_WIN_ANSWER: assert property (
    win && $rose(maint_rsp_valid) |-> ##[2:5] pready) else $error("window answer not returned");
  AST_REG_ZERO_WAIT: assert property (
    psel && !penable && paddr[15:12] != 4'h1 |=> pready ##1 !pready)
    else $error("register access not answered at once");
  AST_UNMAPPED: assert property (
    psel && !penable && !pwrite && paddr[15:12] != 4'h1 && !regs |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind maint_discovery_sequencer maint_seq_checker maint_seq_checker_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .maint_req,
  .maint_req_valid, .maint_rsp_valid, .maint_rsp_data, .maint_rsp_error);

// ===== sim/link_partner_model.sv
// behavioural switch on the far side of the maintenance link
module link_partner_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire maint_seq_pkg::maint_req_s maint_req,
  input wire logic maint_req_valid,
  output logic maint_rsp_valid,
  output logic [31:0] maint_rsp_data,
  output logic maint_rsp_error
);
  timeunit 1ns;
  timeprecision 1ps;
  // the bench sets ident, lock_reg, refuse and fail_link between runs
  logic [31:0] ident, lock_reg, route_dest, route_port;
  logic refuse, fail_link;
  int delay, cnt, n_req;
  maint_seq_pkg::maint_req_s log_q [16];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_rsp_valid <= 1'b0;
      maint_rsp_data <= 32'h5a5a_c3c3;
      maint_rsp_error <= 1'b0;
      cnt <= 0;
    end else if (maint_req_valid && !maint_rsp_valid && cnt < delay) begin
      cnt <= cnt + 1;
    end else if (maint_req_valid && !maint_rsp_valid) begin
      cnt <= 0;
      log_q[n_req % 16] <= maint_req;
      n_req <= n_req + 1;
      maint_rsp_valid <= 1'b1;
      maint_rsp_error <= fail_link;
      // answers go back on the arrival port whatever the dest id
      case (maint_req.offset)
        24'h00_0000: maint_rsp_data <= ident;
        24'h00_0014: maint_rsp_data <= 32'h0000_1002;
        24'h00_0068: maint_rsp_data <= lock_reg;
        default: maint_rsp_data <= {8'ha5, maint_req.offset};
      endcase
      if (maint_req.write && maint_req.offset == 24'h68 && !refuse) begin
        lock_reg <= maint_req.wdata;
      end
      // a write to 0x70 updates only route_dest and a write to 0x74 only route_port
      if (maint_req.write && maint_req.offset == 24'h70) begin
        route_dest <= maint_req.wdata;
      end
      if (maint_req.write && maint_req.offset == 24'h74) begin
        route_port <= maint_req.wdata;
      end
    end else if (!maint_req_valid && maint_rsp_valid) begin
      // released lines must not keep showing the answer
      maint_rsp_valid <= 1'b0;
      maint_rsp_data <= ~maint_rsp_data;
      maint_rsp_error <= ~maint_rsp_error;
    end
  end
endmodule

// ===== sim/maint_discovery_sequencer_tb.sv
// self-checking bench for the maintenance discovery sequencer
module maint_discovery_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SW_ID = 32'h0001_0001; // arbitrary value
  localparam logic [31:0] PR_ID = 32'h0002_0001; // arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, maint_rsp_data;
  logic pready, pslverr, err, maint_req_valid, maint_rsp_valid, maint_rsp_error;
  maint_seq_pkg::maint_req_s maint_req, q;
  logic [23:0] offs [7] = '{24'h0, 24'h14, 24'h68, 24'h68, 24'h68, 24'h70, 24'h74};
  logic [31:0] wds [7] = '{0, 0, 0, 32'h3c, 0, 32'h3c, 32'h02};
  int n_errors = 0;
  int n_tests = 0;
  always #2 pclk = ~pclk;
  maint_discovery_sequencer #(.switch_ident(SW_ID), .processor_ident(PR_ID))
    maint_discovery_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .maint_req, .maint_req_valid, .maint_rsp_valid,
    .maint_rsp_data, .maint_rsp_error);
  link_partner_model link_partner_model_inst (.pclk, .presetn, .maint_req, .maint_req_valid,
    .maint_rsp_valid, .maint_rsp_data, .maint_rsp_error);
  task automatic check(input string name, input logic [72:0] seen, input logic [72:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed: only the watchdog ends a wait that never answers
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // read wdata is a don't care, so it is masked before comparing
  function automatic logic [72:0] req_of(input int i);
    q = link_partner_model_inst.log_q[i];
    return {q.write, q.dest, q.hop, q.offset, q.write ? q.wdata : 32'h0};
  endfunction
  task automatic run_seq(input logic [31:0] id, input logic [31:0] lock, input logic rf,
      input logic le, input logic [31:0] exp, input logic [31:0] mask, input int nreq);
    link_partner_model_inst.ident = id;
    link_partner_model_inst.lock_reg = lock;
    link_partner_model_inst.refuse = rf;
    link_partner_model_inst.fail_link = le;
    link_partner_model_inst.n_req = 0;
    apb(1'b1, maint_seq_pkg::OFF_CONTROL, 32'h0000_3c01);
    for (int i = 0; i < 300 && !(rd[8] | rd[9]); i++) apb(1'b0, maint_seq_pkg::OFF_STATUS, 0);
    check("status", rd & mask, exp);
    check("requests", link_partner_model_inst.n_req, nreq);
    $display("sequence run for identity %h done", id);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    link_partner_model_inst.delay = 1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, maint_seq_pkg::OFF_TARGET, 0);
    check("target reset", rd, 32'h3fc0_0000);
    apb(1'b0, 16'h0ff0, 0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    $display("register test done");
    run_seq(SW_ID, 32'h0000_ffff, 1'b0, 1'b0, 32'h0000_0500, 32'h0000_7f80, 7);
    for (int i = 0; i < 7; i++) begin
      check("switch req", req_of(i), {i == 3 || i > 4, 16'hff00, offs[i], wds[i]});
    end
    apb(1'b0, maint_seq_pkg::OFF_PORT_INFO, 0);
    check("port info", rd, 32'h0000_1002);
    apb(1'b0, maint_seq_pkg::OFF_LOCK_VALUE, 0);
    check("lock value", rd, 32'h0000_003c);
    check("route", {link_partner_model_inst.route_dest, link_partner_model_inst.route_port},
      {32'h3c, 32'h02});
    run_seq(PR_ID, 32'h0000_ffff, 1'b0, 1'b0, 32'h0000_0900, 32'h0000_7f80, 1);
    run_seq(32'h1234_5678, 32'h0000_ffff, 1'b0, 1'b0, 32'h0000_1200, 32'h0000_7380, 1);
    run_seq(SW_ID, 32'h0000_0007, 1'b0, 1'b0, 32'h0000_2200, 32'h0000_7380, 3);
    run_seq(SW_ID, 32'h0000_ffff, 1'b1, 1'b0, 32'h0000_3200, 32'h0000_7380, 5);
    run_seq(SW_ID, 32'h0000_ffff, 1'b0, 1'b1, 32'h0000_4200, 32'h0000_7380, 1);
    link_partner_model_inst.fail_link = 1'b0;
    link_partner_model_inst.delay = 6;
    link_partner_model_inst.n_req = 0;
    apb(1'b1, maint_seq_pkg::OFF_TARGET, 32'h0483_4abc);
    apb(1'b0, 16'h1568, 0);
    check("window read", {err, rd}, {1'b0, 32'ha5ab_c568});
    check("window rd req", req_of(0), {1'b0, 16'h1234, 24'habc568, 32'h0});
    apb(1'b1, 16'h1ffc, 32'hdead_beef);
    check("window wr req", req_of(1), {1'b1, 16'h1234, 24'habcffc, 32'hdead_beef});
    link_partner_model_inst.fail_link = 1'b1;
    apb(1'b0, 16'h1000, 0);
    check("window error", err, 1'b1);
    $display("window test done");
    final_report();
  end
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule
